// >>> design/acc_pkg.sv
package acc_pkg;
   // ------------------------------------------------------------
   // register byte addresses (word aligned)
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL1_ADDR = 4'h0;
   localparam logic [3:0] CTRL2_ADDR = 4'h4;
   localparam logic [3:0] PORTDIS_ADDR = 4'h8;
   localparam logic [3:0] IRQ_STAT_ADDR = 4'hc;
   // ------------------------------------------------------------
   // control register 1 field positions
   // ------------------------------------------------------------
   localparam int C1_FLAG = 0;
   localparam int C1_IE = 1;
   localparam int C1_IES = 2;
   localparam int C1_ON = 3;
   localparam int C1_REF_LO = 4;
   localparam int C1_RSEL = 6;
   localparam int C1_EX = 7;
   // ------------------------------------------------------------
   // control register 2 field positions
   // ------------------------------------------------------------
   localparam int C2_OUT = 0;
   localparam int C2_FILT = 1;
   localparam int C2_SW0 = 2;
   localparam int C2_SW1 = 3;
   // ------------------------------------------------------------
   // reset values and widths
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int PORT_W = 8;
   localparam int FILT_LEN = 4;
   localparam logic [31:0] UNMAPPED_RD = 32'h00000000;
   // ------------------------------------------------------------
   // reference level codes
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      REF_OFF = 2'h0,
      REF_QUARTER = 2'h1,
      REF_HALF = 2'h2,
      REF_DIODE = 2'h3
   } acc_ref_t;
   // analog front-end control bundle
   typedef struct packed
   {
      logic power_on;
      logic swap_inputs;
      acc_ref_t ref_level;
      logic ref_to_pos;
      logic ref_to_neg;
      logic pin_switch_0;
      logic pin_switch_1;
   } acc_analog_t;
endpackage : acc_pkg

// >>> design/acc_filter.sv
module acc_filter #(
   parameter int LEN = acc_pkg::FILT_LEN
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_din,
   output logic o_dout
);
   // ------------------------------------------------------------
   // majority-free hold filter
   // ------------------------------------------------------------
   logic [LEN-1:0] hist_q;
   logic dout_q;

   // shift history; output changes only once the input stays put,
   // which trades LEN+1 cycles of latency for no chatter near threshold
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         hist_q <= '0;
         dout_q <= 1'b0;
      end
      else
      begin
         hist_q <= {hist_q[LEN-2:0], i_din};
         if (&hist_q)
            dout_q <= 1'b1;
         else if (~|hist_q)
            dout_q <= 1'b0;
      end
   end

   assign o_dout = dout_q;
endmodule : acc_filter

// >>> design/acc_top.sv
// What this block does
// - result high when positive exceeds negative
// - power bit; result low while off
// - exchange swaps terminals and inverts result
// - filter bit selects filtered result
// - reference level and terminal drive outputs
// - two pin switch bits
// - port buffer disable per pin
// - flag set on selected result edge
// - request needs enable and global enable
// - flag cleared on service or software
// - one flag and one vector
// - result routed to timer capture input
// - reference code 00 means off
// - reference terminal mapping flips with exchange
// - result bit is read-only
// - polarity 0 rising, 1 falling
module acc_top
(
   input wire logic i_clk,
   input wire logic i_rstn,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // analog comparator core
   input wire logic i_comparison_raw,
   output acc_pkg::acc_analog_t o_analog,
   output logic [acc_pkg::PORT_W-1:0] o_port_buffer_disable,
   // interrupt and timer
   input wire logic i_global_irq_enable,
   input wire logic i_irq_ack,
   output logic o_irq,
   output logic o_timer_capture_input_b
);
   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   logic [7:1] ctrl1_q;
   logic flag_q;
   logic ex_d1_q;
   logic ex_d2_q;
   logic [3:0] ctrl2_q;
   logic [acc_pkg::PORT_W-1:0] portdis_q;
   logic sync1_q;
   logic sync2_q;
   logic result_prev_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic comparator_power_on;
   logic input_exchange;
   logic output_filter_enable;
   logic edge_polarity_select;
   logic compare_irq_enable;
   logic compare_irq_flag;
   logic reference_terminal_select;
   logic [1:0] reference_level_select;
   logic raw_cmp;
   logic filt_cmp;
   logic comparison_result;
   logic rise;
   logic fall;
   logic edge_hit;
   logic wr_c1;
   logic wr_c2;
   logic wr_pd;
   logic wr_stat;
   logic sw_clr;

   assign comparator_power_on = ctrl1_q[acc_pkg::C1_ON];
   assign input_exchange = ctrl1_q[acc_pkg::C1_EX];
   assign edge_polarity_select = ctrl1_q[acc_pkg::C1_IES];
   assign compare_irq_enable = ctrl1_q[acc_pkg::C1_IE];
   assign compare_irq_flag = flag_q;
   assign reference_terminal_select = ctrl1_q[acc_pkg::C1_RSEL];
   assign reference_level_select = ctrl1_q[acc_pkg::C1_REF_LO +: 2];
   assign output_filter_enable = ctrl2_q[acc_pkg::C2_FILT];

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // single-cycle slave: waitrequest high on the first cycle of any
   // request, low on the next, so the write lands exactly once
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         ack_q <= 1'b0;
      else
         ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
   end

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

   // write strobes act only in the accepting cycle, lane 0 only
   always_comb
   begin
      wr_c1 = 1'b0;
      wr_c2 = 1'b0;
      wr_pd = 1'b0;
      wr_stat = 1'b0;
      if (i_avs_write && ack_q && i_avs_byteenable[0])
      begin
         if (i_avs_address == acc_pkg::CTRL1_ADDR)
            wr_c1 = 1'b1;
         else if (i_avs_address == acc_pkg::CTRL2_ADDR)
            wr_c2 = 1'b1;
         else if (i_avs_address == acc_pkg::PORTDIS_ADDR)
            wr_pd = 1'b1;
         else if (i_avs_address == acc_pkg::IRQ_STAT_ADDR)
            wr_stat = 1'b1;
      end
   end

   // software clear: write 0 to flag in ctrl1, or 1 to status clear
   assign sw_clr = (wr_c1 & ~i_avs_writedata[acc_pkg::C1_FLAG])
                 | (wr_stat & i_avs_writedata[0]);

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // control bits except the flag, which has its own process
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         ctrl1_q[7:1] <= acc_pkg::CTRL_RST[7:1];
      else if (wr_c1)
         ctrl1_q[7:1] <= i_avs_writedata[7:1];
   end

   // result bit is not stored: bit 0 of ctrl2 is never written
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         ctrl2_q <= acc_pkg::CTRL_RST[3:0];
      else if (wr_c2)
         ctrl2_q <= {i_avs_writedata[3:1], 1'b0};
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         portdis_q <= acc_pkg::CTRL_RST[acc_pkg::PORT_W-1:0];
      else if (wr_pd)
         portdis_q <= i_avs_writedata[acc_pkg::PORT_W-1:0];
   end

   assign o_port_buffer_disable = portdis_q;

   // ------------------------------------------------------------
   // comparator result path
   // ------------------------------------------------------------
   // two-stage synchronizer; the first stage feeds nothing else
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end
      else
      begin
         sync1_q <= i_comparison_raw;
         sync2_q <= sync1_q;
      end
   end

   // exchange bit delayed by the same two stages as the result, so the
   // inversion meets the first sample taken after the swap; inverting
   // the stale samples would fake an edge and set the flag
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ex_d1_q <= 1'b0;
         ex_d2_q <= 1'b0;
      end
      else
      begin
         ex_d1_q <= input_exchange;
         ex_d2_q <= ex_d1_q;
      end
   end

   // the core swaps terminals itself, so invert to keep polarity;
   // a slow core may still show one stale cycle around a swap
   assign raw_cmp = sync2_q ^ ex_d2_q;

   acc_filter #(
      .LEN(acc_pkg::FILT_LEN)
   ) u_filter (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_din(raw_cmp),
      .o_dout(filt_cmp)
   );

   // gated by power so a powered-off comparator reads low
   assign comparison_result = comparator_power_on
      & (output_filter_enable ? filt_cmp : raw_cmp);

   assign o_timer_capture_input_b = comparison_result;

   // ------------------------------------------------------------
   // edge detection and interrupt flag
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         result_prev_q <= 1'b0;
      else
         result_prev_q <= comparison_result;
   end

   assign rise = comparison_result & ~result_prev_q;
   assign fall = ~comparison_result & result_prev_q;
   assign edge_hit = edge_polarity_select ? fall : rise;

   // set wins over service and software clear in the same cycle;
   // a software write of 1 to the flag also sets it
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         flag_q <= 1'b0;
      else if (edge_hit || (wr_c1 && i_avs_writedata[acc_pkg::C1_FLAG]))
         flag_q <= 1'b1;
      else if (sw_clr || i_irq_ack)
         flag_q <= 1'b0;
   end

   // one flag drives the single request line (one vector)
   assign o_irq = compare_irq_flag & compare_irq_enable
                & i_global_irq_enable;

   // ------------------------------------------------------------
   // analog control outputs
   // ------------------------------------------------------------
   // reference goes to + when select equals exchange, else to -
   always_comb
   begin
      o_analog.power_on = comparator_power_on;
      o_analog.swap_inputs = input_exchange;
      o_analog.ref_level = acc_pkg::acc_ref_t'(reference_level_select);
      o_analog.ref_to_pos = 1'b0;
      o_analog.ref_to_neg = 1'b0;
      if (reference_level_select != acc_pkg::REF_OFF)
      begin
         if (reference_terminal_select == input_exchange)
            o_analog.ref_to_pos = 1'b1;
         else
            o_analog.ref_to_neg = 1'b1;
      end
      o_analog.pin_switch_0 = ctrl2_q[acc_pkg::C2_SW0];
      o_analog.pin_switch_1 = ctrl2_q[acc_pkg::C2_SW1];
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // address mux; unmapped offsets read as the neutral value
   always_comb
   begin
      rdata_d = acc_pkg::UNMAPPED_RD;
      if (i_avs_address == acc_pkg::CTRL1_ADDR)
         rdata_d = {24'h000000, ctrl1_q, flag_q};
      else if (i_avs_address == acc_pkg::CTRL2_ADDR)
         rdata_d = {28'h0000000, ctrl2_q[3:1], comparison_result};
      else if (i_avs_address == acc_pkg::PORTDIS_ADDR)
         rdata_d = {24'h000000, portdis_q};
      else if (i_avs_address == acc_pkg::IRQ_STAT_ADDR)
         rdata_d = {31'h00000000, compare_irq_flag};
   end

   // captured on the first request cycle, stands at the accept edge
   // and after it, until the next read replaces it
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         rdata_q <= acc_pkg::UNMAPPED_RD;
      else if (i_avs_read && !ack_q)
         rdata_q <= rdata_d;
   end

   assign o_avs_readdata = rdata_q;
endmodule : acc_top

// >>> tb/acc_monitor.sv
module acc_monitor
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic i_global_irq_enable,
   input wire logic i_irq_ack,
   input wire logic o_irq,
   input wire logic o_timer_capture_input_b,
   input wire acc_pkg::acc_analog_t o_analog
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // bus, interrupt, power and reference checks
   // ------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   wire logic req = i_avs_read | i_avs_write;
   wire logic cap = o_timer_capture_input_b;
   sequence req_start;
      req && !$past(req);
   endsequence
   sequence accepted;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   wait_first_a:
      assert property (req_start |-> accepted) else $error("bad wait");
   idle_ready_a:
      assert property (!req |-> !o_avs_waitrequest) else $error("idle wait");
   power_gate_a:
      assert property (!o_analog.power_on |-> !cap) else $error("off high");
   irq_global_a:
      assert property (!i_global_irq_enable |-> !o_irq) else $error("irq gie");
   irq_ack_a:
      assert property (i_irq_ack && $stable(cap) |=> !o_irq)
         else $error("ack kept irq");
   irq_cause_a:
      assert property ($rose(o_irq) |-> $rose(i_global_irq_enable)
         || $past(req) || $past(cap) != $past(cap, 2)) else $error("irq cause");
   ref_off_a:
      assert property (o_analog.ref_level == acc_pkg::REF_OFF
         |-> !(o_analog.ref_to_pos || o_analog.ref_to_neg)) else $error("ref");
   ref_one_a:
      assert property (o_analog.ref_level != acc_pkg::REF_OFF
         |-> o_analog.ref_to_pos != o_analog.ref_to_neg) else $error("route");
endmodule : acc_monitor

// >>> tb/acc_comp_model.sv
module acc_comp_model #(
   parameter int VCC_MV = 3000,
   parameter int DIODE_MV = 550
)
(
   input wire acc_pkg::acc_analog_t i_analog,
   input int i_pin0_mv,
   input int i_pin1_mv,
   output logic o_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   int vref, a, b, vp, vn;
   // analog core; an open pin switch reads 0 mV, never a floating level
   always_comb
   begin
      case (i_analog.ref_level)
         acc_pkg::REF_QUARTER: vref = VCC_MV / 4;
         acc_pkg::REF_HALF: vref = VCC_MV / 2;
         acc_pkg::REF_DIODE: vref = DIODE_MV;
         default: vref = 0;
      endcase
      a = i_analog.pin_switch_0 ? i_pin0_mv : 0;
      b = i_analog.pin_switch_1 ? i_pin1_mv : 0;
      vp = i_analog.swap_inputs ? b : a;
      vn = i_analog.swap_inputs ? a : b;
      if (i_analog.ref_to_pos)
         vp = vref;
      if (i_analog.ref_to_neg)
         vn = vref;
      o_raw = i_analog.power_on && (vp > vn);
   end
endmodule : acc_comp_model

// >>> tb/acc_tb_top.sv
module acc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] C1 = acc_pkg::CTRL1_ADDR;
   localparam logic [3:0] C2 = acc_pkg::CTRL2_ADDR;
   localparam logic [3:0] PD = acc_pkg::PORTDIS_ADDR;
   localparam logic [3:0] ST = acc_pkg::IRQ_STAT_ADDR;
   logic i_clk, i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [3:0] i_avs_address, i_avs_byteenable;
   logic [31:0] i_avs_writedata, o_avs_readdata, q;
   logic i_global_irq_enable, i_irq_ack, i_comparison_raw, o_irq, hi;
   logic o_timer_capture_input_b;
   acc_pkg::acc_analog_t o_analog;
   logic [acc_pkg::PORT_W-1:0] o_port_buffer_disable;
   logic [4:0] i;
   logic [1:0] e;
   int pin0_mv, pin1_mv, fails, tests_run;
   acc_top uut (.i_clk, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
      .i_comparison_raw, .o_analog, .o_port_buffer_disable, .i_global_irq_enable,
      .i_irq_ack, .o_irq, .o_timer_capture_input_b);
   acc_comp_model far (.i_analog(o_analog), .i_pin0_mv(pin0_mv),
      .i_pin1_mv(pin1_mv), .o_raw(i_comparison_raw));
   // ------
   // clock and tasks
   // ------
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task report_and_stop;
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // waitrequest and read data are read at the rising edge that takes
   // them, before that edge's own updates land
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
      int n;
      @(posedge i_clk);
      i_avs_read <= !wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40)
      begin
         fails++;
         report_and_stop;
      end
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus
   task wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
      @(negedge i_clk);
   endtask : wr
   task rd(input string what, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      check(what, q, exp);
   endtask : rd
   // two sync flops, four filter samples and the flag edge fit in eight
   task volts(input int mv);
      @(posedge i_clk);
      pin0_mv <= mv;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
   endtask : volts
   task glitch(input int mv);
      int old, k;
      old = pin0_mv;
      hi = 1'b0;
      for (k = 0; k < 12; k++)
      begin
         @(posedge i_clk);
         pin0_mv <= (k < 2) ? mv : old;
         @(negedge i_clk);
         hi = hi | o_timer_capture_input_b;
      end
   endtask : glitch
   // ------
   // main sequence
   // ------
   initial
   begin
      {i_rstn, i_avs_read, i_avs_write, i_irq_ack} = 4'h0;
      {i_avs_address, i_avs_byteenable, i_avs_writedata} = '0;
      i_global_irq_enable = 1'b0;
      {pin0_mv, pin1_mv, fails, tests_run} = {32'd2000, 32'd1000, 64'd0};
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(negedge i_clk);
      check("analog", o_analog, 32'h0);
      check("port_pins", o_port_buffer_disable, 32'h0);
      rd("ctrl1", C1, 32'h0);
      rd("ctrl2", C2, 32'h0);
      rd("portdis", PD, 32'h0);
      rd("stat", ST, 32'h0);
      rd("unmapped", 4'h1, acc_pkg::UNMAPPED_RD);
      wr(PD, 32'ha5);
      bus(1'b1, PD, 32'hff, 4'he);
      rd("portdis", PD, 32'ha5);
      check("port_pins", o_port_buffer_disable, 32'ha5);
      for (i = 0; i < 16; i++)
      begin
         wr(C1, {24'h0, i[3:0], 4'h0});
         e = (i[1:0] == 2'h0) ? 2'h0 : (i[3] ^ i[2]) ? 2'h1 : 2'h2;
         check("ref", {o_analog[5:2]}, {i[1:0], e});
      end
      wr(C2, 32'h0d);
      volts(2000);
      rd("ctrl2", C2, 32'h0c);
      check("switch", o_analog[1:0], 32'h3);
      wr(C1, 32'h08);
      volts(2000);
      check("cap", o_timer_capture_input_b, 32'h1);
      rd("ctrl2", C2, 32'h0d);
      wr(C1, 32'h88);
      volts(2000);
      check("cap", o_timer_capture_input_b, 32'h1);
      rd("stat", ST, 32'h0);
      @(posedge i_clk);
      i_global_irq_enable <= 1'b1;
      wr(C1, 32'h0a);
      volts(2000);
      wr(ST, 32'h1);
      check("irq", o_irq, 32'h0);
      volts(500);
      check("irq", o_irq, 32'h0);
      volts(2000);
      check("irq", o_irq, 32'h1);
      rd("stat", ST, 32'h1);
      @(posedge i_clk);
      i_global_irq_enable <= 1'b0;
      @(negedge i_clk);
      check("irq", o_irq, 32'h0);
      @(posedge i_clk);
      i_global_irq_enable <= 1'b1;
      i_irq_ack <= 1'b1;
      @(posedge i_clk);
      i_irq_ack <= 1'b0;
      @(negedge i_clk);
      check("irq", o_irq, 32'h0);
      rd("stat", ST, 32'h0);
      wr(C1, 32'h0e);
      volts(500);
      check("irq", o_irq, 32'h1);
      wr(C1, 32'h0d);
      check("irq", o_irq, 32'h0);
      wr(ST, 32'h1);
      rd("stat", ST, 32'h0);
      wr(C2, 32'h0e);
      glitch(2000);
      check("filtered", hi, 32'h0);
      wr(C2, 32'h0c);
      glitch(2000);
      check("unfiltered", hi, 32'h1);
      volts(2000);
      check("cap", o_timer_capture_input_b, 32'h1);
      wr(C1, 32'h00);
      check("cap", o_timer_capture_input_b, 32'h0);
      rd("ctrl2", C2, 32'h0c);
      report_and_stop;
   end
endmodule : acc_tb_top
bind acc_top acc_monitor mon (.i_clk, .i_rstn, .i_avs_read, .i_avs_write,
   .o_avs_waitrequest, .i_global_irq_enable, .i_irq_ack, .o_irq,
   .o_timer_capture_input_b, .o_analog);
